// ===== utb_pkg.sv
// constants for the serial transmitter block with break and queued idle
// assumes a 32-bit axi4-lite register bus and one 20 MHz clock
package utb_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam logic [4:0] ADR_BAUD = 5'h00;
  localparam logic [4:0] ADR_CTRL = 5'h04;
  localparam logic [4:0] ADR_STAT = 5'h08;
  localparam logic [4:0] ADR_DATA = 5'h0c;
  // baud_high layout
  localparam int BD_DIV_W = 13;
  localparam int BD_TWO_STOP = 13;
  localparam logic [12:0] BD_DIV_RST = 13'h0004;
  // control_two layout
  localparam int CT_TX_ON = 0;
  localparam int CT_RX_ON = 1;
  localparam int CT_QBRK = 2;
  localparam int CT_NINE = 3;
  localparam int CT_LBRK = 4;
  localparam int CT_FLIP = 5;
  localparam logic [5:0] CT_RST = 6'h00;
  // status_one layout
  localparam int ST_TX_BUFFER_FREE_FLAG = 0;
  localparam int ST_TC = 1;
  localparam int ST_RXF = 2;
  localparam int ST_FE = 3;
  localparam int ST_BUSY = 4;
  // frame shape
  localparam logic [3:0] OVS = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] FRM_BASE = 4'ha;
  localparam logic [3:0] BRK_LONG_ADD = 4'h3;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
endpackage

// ===== utb_rx_model.sv
// remote serial receiver model watching the transmit line
// assumes the line idles high and one bit lasts sixteen times the divisor in clocks
`timescale 1ns/1ps
module utb_rx_model (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic [12:0] div_i,
  output logic [7:0] data_o,
  output logic fe_o,
  output int n_o,
  output int low_o
);
  int run;
  initial begin
    data_o = 8'h00;
    fe_o = 1'b0;
    n_o = 0;
    low_o = 0;
    run = 0;
  end
  // length of the last low stretch, so break lengths can be judged in clocks
  always @(posedge clk_i) begin
    if (line_i === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run != 0) low_o <= run;
      run <= 0;
    end
  end
  // single mid-bit sample, no realignment: a slow or fast sender shows up as bad data
  initial begin : rx
    int bt;
    forever begin
      @(negedge line_i);
      bt = 16 * int'(div_i);
      repeat (bt / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bt) @(posedge clk_i);
        data_o[i] = line_i;
      end
      repeat (bt) @(posedge clk_i);
      fe_o = (line_i !== 1'b1);
      n_o = n_o + 1;
      wait (line_i === 1'b1);
    end
  end
endmodule

// ===== utb_top.sv
// serial transmitter with break/idle queueing, a small receiver and an axi4-lite slave
// assumes the pin mux turns tx_oe_o into pin ownership and rxd_i is asynchronous
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module utb_top import utb_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_i,
  output logic txd_o,
  output logic tx_oe_o
);
  typedef enum logic [1:0] {UTB_K_DATA, UTB_K_IDLE, UTB_K_BRK} utb_kind_t;
  typedef enum logic {UTB_RX_WAIT, UTB_RX_RUN} utb_rx_t;

  logic [BD_DIV_W-1:0] div_q, dcnt_q;
  logic two_stop_sel_q;
  logic [5:0] ctl_q;
  logic tick_q;
  logic tx_buffer_free_flag_q, tc_q, rxf_q, framing_err_flag_q, armed_q;
  logic [8:0] txbuf_q, rxbuf_q, rsh_q;
  logic [4:0] awa_q;
  logic aw_q, w_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic busy_q, idle_pend_q, brk_pend_q;
  utb_kind_t kind_q, kind_d;
  logic [11:0] sh_q;
  logic [3:0] sub_q, left_q, rsub_q, rbit_q;
  utb_rx_t rst_q;
  logic rx_m_q, rx_s_q, rx_p_q;
  logic tx_on, qbrk, nine, flip;
  logic do_wr, st_rd, dat_wr, dat_rd, ctl_wr;
  logic bit_end, frame_end, can_load, want_data, load;
  logic [3:0] frm_len, brk_len;
  logic [31:0] merged;
  logic rx_fall;

  assign tx_on = ctl_q[CT_TX_ON];
  assign qbrk = ctl_q[CT_QBRK];
  assign nine = ctl_q[CT_NINE];
  assign flip = ctl_q[CT_FLIP];
  assign frm_len = FRM_BASE + {3'h0, nine} + {3'h0, two_stop_sel_q};
  assign brk_len = frm_len + (ctl_q[CT_LBRK] ? BRK_LONG_ADD : 4'h0);

  // ---- axi4-lite slave: address and data taken in either order ----
  assign do_wr = aw_q && w_q && !s_axi_bvalid;
  assign ctl_wr = do_wr && awa_q == ADR_CTRL;
  assign dat_wr = do_wr && awa_q == ADR_DATA;
  assign st_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADR_STAT;
  assign dat_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADR_DATA;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  always_comb begin
    unique case (awa_q)
      ADR_BAUD: merged = lane_merge({18'h0, two_stop_sel_q, div_q}, wd_q, ws_q);
      ADR_CTRL: merged = lane_merge({26'h0, ctl_q}, wd_q, ws_q);
      default: merged = lane_merge({23'h0, txbuf_q}, wd_q, ws_q);
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 5'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        // only the three writable words answer okay; status and holes refuse the write
        s_axi_bresp <= (awa_q == ADR_BAUD || awa_q == ADR_CTRL || awa_q == ADR_DATA) ?
          RESP_OK : RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OK;
        unique case (s_axi_araddr)
          ADR_BAUD: s_axi_rdata <= {18'h0, two_stop_sel_q, div_q};
          ADR_CTRL: s_axi_rdata <= {26'h0, ctl_q};
          ADR_STAT: s_axi_rdata <= {27'h0, busy_q, framing_err_flag_q, rxf_q, tc_q,
                                     tx_buffer_free_flag_q};
          ADR_DATA: s_axi_rdata <= {23'h0, rxbuf_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---- configuration registers ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= BD_DIV_RST;
      two_stop_sel_q <= 1'b0;
      ctl_q <= CT_RST;
      txbuf_q <= 9'h000;
    end else if (do_wr) begin
      if (awa_q == ADR_BAUD) begin
        div_q <= merged[BD_DIV_W-1:0];
        two_stop_sel_q <= merged[BD_TWO_STOP];
      end
      if (ctl_wr) ctl_q <= merged[5:0];
      if (dat_wr) txbuf_q <= merged[8:0];
    end
  end

  // ---- baud generator: modulo divider of the bus clock ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dcnt_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == '0) begin
      dcnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= dcnt_q >= div_q - 13'h0001;
      dcnt_q <= (dcnt_q >= div_q - 13'h0001) ? '0 : dcnt_q + 13'h0001;
    end
  end

  // ---- status flags; the status read arms the clearing access ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      tx_buffer_free_flag_q <= 1'b1;
      tc_q <= 1'b1;
    end else begin
      if (st_rd) armed_q <= 1'b1;
      else if (dat_wr || dat_rd) armed_q <= 1'b0;
      if (dat_wr && armed_q) begin
        tx_buffer_free_flag_q <= 1'b0;
        tc_q <= 1'b0;
      end
      if (load && kind_d == UTB_K_DATA) tx_buffer_free_flag_q <= 1'b1;
      if (load) tc_q <= 1'b0;
      if (frame_end && !load) tc_q <= 1'b1;
    end
  end

  // ---- transmitter: one shifter fed by idle, break or buffered data ----
  assign bit_end = tick_q && sub_q == OVS;
  assign frame_end = busy_q && bit_end && left_q == 4'h1;
  assign can_load = (!busy_q && tick_q) || frame_end;
  assign want_data = tx_on && !tx_buffer_free_flag_q;
  assign load = can_load && (idle_pend_q || brk_pend_q || want_data);

  always_comb begin
    if (idle_pend_q) kind_d = UTB_K_IDLE;
    else if (brk_pend_q) kind_d = UTB_K_BRK;
    else kind_d = UTB_K_DATA;
  end

  // queued idle and break survive enable going low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (load && kind_d == UTB_K_IDLE) idle_pend_q <= 1'b0;
      if (load && kind_d == UTB_K_BRK) brk_pend_q <= qbrk;
      if (ctl_wr && merged[CT_TX_ON] && !tx_on) idle_pend_q <= 1'b1;
      if (ctl_wr && merged[CT_QBRK] && !qbrk) brk_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      kind_q <= UTB_K_IDLE;
      sh_q <= 12'hfff;
      sub_q <= 4'h0;
      left_q <= 4'h0;
    end else if (load) begin
      busy_q <= 1'b1;
      kind_q <= kind_d;
      sub_q <= 4'h0;
      left_q <= (kind_d == UTB_K_BRK) ? brk_len : frm_len;
      sh_q <= 12'hfff;
      if (kind_d == UTB_K_DATA) begin
        sh_q[0] <= 1'b0;
        sh_q[8:1] <= txbuf_q[7:0];
        if (nine) sh_q[9] <= txbuf_q[8];
      end
    end else if (busy_q && tick_q) begin
      sub_q <= sub_q + 4'h1;
      if (sub_q == OVS) begin
        sh_q <= {1'b1, sh_q[11:1]};
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1) busy_q <= 1'b0;
      end
    end
  end

  // pin stays owned while enabled, shifting or with frames queued
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
      tx_oe_o <= 1'b0;
    end else begin
      tx_oe_o <= tx_on || busy_q || idle_pend_q || brk_pend_q;
      if (busy_q && kind_q == UTB_K_BRK) txd_o <= flip;
      else if (busy_q) txd_o <= sh_q[0] ^ flip;
      else txd_o <= !flip;
    end
  end

  // ---- receiver: 16x sampling, realigned on each falling edge ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_p_q <= 1'b1;
    end else begin
      rx_m_q <= rxd_i;
      rx_s_q <= rx_m_q;
      rx_p_q <= rx_s_q;
    end
  end
  assign rx_fall = rx_p_q && !rx_s_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_q <= UTB_RX_WAIT;
      rsub_q <= 4'h0;
      rbit_q <= 4'h0;
      rsh_q <= 9'h000;
      rxbuf_q <= 9'h000;
      rxf_q <= 1'b0;
      framing_err_flag_q <= 1'b0;
    end else begin
      if (dat_rd && armed_q) begin
        rxf_q <= 1'b0;
        framing_err_flag_q <= 1'b0;
      end
      unique case (rst_q)
        UTB_RX_WAIT: begin
          if (rx_fall && ctl_q[CT_RX_ON]) begin
            rst_q <= UTB_RX_RUN;
            rsub_q <= 4'h0;
            rbit_q <= 4'h0;
          end
        end
        UTB_RX_RUN: begin
          if (rx_fall) begin
            rsub_q <= 4'h0;
            if (rsub_q > OVS_MID) rbit_q <= rbit_q + 4'h1;
          end else if (tick_q) begin
            rsub_q <= rsub_q + 4'h1;
            if (rsub_q == OVS) rbit_q <= rbit_q + 4'h1;
            if (rsub_q == OVS_MID) begin
              if (rbit_q == 4'h0 && rx_s_q) rst_q <= UTB_RX_WAIT;
              else if (rbit_q == {3'h0, nine} + 4'h9) begin
                rst_q <= UTB_RX_WAIT;
                if (!rxf_q && !framing_err_flag_q) begin
                  rxbuf_q <= nine ? rsh_q : {1'b0, rsh_q[8:1]};
                  rxf_q <= 1'b1;
                end
                if (!rx_s_q) framing_err_flag_q <= 1'b1;
              end else if (rbit_q != 4'h0) rsh_q <= {rx_s_q, rsh_q[8:1]};
            end
          end
        end
      endcase
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_data_frees_buf: assert property (load && kind_d == UTB_K_DATA |=>
    tx_buffer_free_flag_q && left_q == $past(frm_len)) else $error("data load wrong");
  a_break_length: assert property (load && kind_d == UTB_K_BRK |=>
    left_q == FRM_BASE + 4'($past(nine)) + 4'($past(two_stop_sel_q))
      + ($past(ctl_q[CT_LBRK]) ? 4'h3 : 4'h0)) else $error("break length wrong");
  a_break_low: assert property (busy_q && kind_q == UTB_K_BRK && !flip |=> !txd_o)
    else $error("break not low");
  a_idle_high: assert property (!busy_q && !flip |=> txd_o) else $error("idle not high");
  a_pin_kept: assert property (busy_q |=> tx_oe_o) else $error("pin released early");
  a_done_flag: assert property (frame_end && !load |=> tc_q && !busy_q)
    else $error("complete flag missing");
  a_rebreak: assert property (load && kind_d == UTB_K_BRK && qbrk |=> brk_pend_q)
    else $error("break not requeued");
  a_div_stop: assert property (div_q == '0 |=> !tick_q) else $error("tick with zero div");
  a_rx_realign: assert property (rst_q == UTB_RX_RUN && rx_fall |=> rsub_q == 4'h0)
    else $error("no realign");
  a_idle_queued: assert property (ctl_wr && merged[CT_TX_ON] && !tx_on |=> idle_pend_q)
    else $error("idle not queued");
  a_bit_span: assert property (busy_q && !load && !(tick_q && sub_q == OVS) |=>
    $stable(left_q)) else $error("bit span wrong");

  c_break_sent: cover property (frame_end && kind_q == UTB_K_BRK);
  c_idle_sent: cover property (frame_end && kind_q == UTB_K_IDLE);
  c_data_back: cover property (frame_end && load && kind_d == UTB_K_DATA);
  c_rx_frame: cover property ($rose(rxf_q));
endmodule

// ===== utb_top_tb.sv
// self-checking bench for the serial transmitter over axi4-lite
// assumes the released pin is pulled high and the tx line is looped back to rxd_i
`timescale 1ns/1ps
module utb_top_tb;
  import utb_pkg::*;
  localparam logic [12:0] DIV = 13'h0002;
  localparam int BT = 32;
  logic clk_i, rst_i;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic txd_o, tx_oe_o, line;
  logic [7:0] rx_data;
  logic rx_fe;
  int n_rx, low_run, n_mismatch, num_checks, cyc;
  assign line = tx_oe_o ? txd_o : 1'b1;
  utb_top utb_top_i (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rxd_i(line), .txd_o(txd_o), .tx_oe_o(tx_oe_o));
  utb_rx_model utb_rx_model_i (.clk_i(clk_i), .line_i(line), .div_i(DIV), .data_o(rx_data),
    .fe_o(rx_fe), .n_o(n_rx), .low_o(low_run));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // valid and payload hold until their own ready; bready stays up until bvalid is seen
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OK}, "write resp");
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
      input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e, what);
  endtask
  // status read arms the flag clear that lets the written byte go out
  task automatic send(input logic [7:0] b);
    logic [31:0] d;
    logic [1:0] r;
    rd(ADR_STAT, d, r);
    wreg(ADR_DATA, {24'h0, b});
  endtask
  task automatic wait_flag(input int bitn);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 500; i++) begin
      rd(ADR_STAT, d, r);
      if (d[bitn] === 1'b1) break;
    end
  endtask
  task automatic wait_rx(input int k);
    for (int i = 0; i < 3000 && n_rx < k; i++) @(posedge clk_i);
  endtask
  task automatic wait_high();
    for (int i = 0; i < 3000 && line !== 1'b1; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int t, n0, ex;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    rst_i = 1'b1;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ADR_BAUD, 32'h3fff, 32'h4, "baud reset");
    rchk(ADR_CTRL, 32'h3f, 32'h0, "control reset");
    rchk(ADR_STAT, 32'h1f, 32'h3, "status reset");
    chk(txd_o, 1'b1, "idle level");
    rd(5'h10, d, r);
    chk(d, 32'h0, "unmapped data");
    chk(r, RESP_ERR, "unmapped resp");
    wr(ADR_STAT, 32'hff, r);
    chk(r, RESP_ERR, "status write resp");
    wr(5'h10, 32'h0, r);
    chk(r, RESP_ERR, "unmapped write resp");
    wreg(ADR_BAUD, {19'h0, DIV});
    wreg(ADR_CTRL, 32'h3);
    send(8'ha5);
    t = 0;
    while (txd_o === 1'b1 && t < 2000) begin
      @(posedge clk_i);
      t++;
    end
    chk(t >= 10 * BT - 24, 1'b1, "idle frame first");
    wait_flag(ST_TX_BUFFER_FREE_FLAG);
    send(8'h3c);
    wait_rx(1);
    chk(rx_data, 8'ha5, "first byte");
    chk(rx_fe, 1'b0, "first stop");
    wait_rx(2);
    chk(rx_data, 8'h3c, "second byte");
    wait_flag(ST_TC);
    chk(txd_o, 1'b1, "idle after frame");
    rchk(ADR_DATA, 32'h1ff, 32'ha5, "rx buffer");
    send(8'h5a);
    wreg(ADR_CTRL, 32'h2);
    chk(tx_oe_o, 1'b1, "pin kept");
    wait_rx(3);
    chk(rx_data, 8'h5a, "byte after disable");
    wait_flag(ST_TC);
    repeat (4) @(posedge clk_i);
    chk(tx_oe_o, 1'b0, "pin released");
    // every long-break, nine-bit and two-stop combination, one break each
    for (int k = 0; k < 8; k++) begin
      ex = 10 + k[1] + k[0] + 3 * k[2];
      wreg(ADR_BAUD, {18'h0, k[0], DIV});
      // enable low then high queues an idle frame, so the break waits behind a busy shifter
      wreg(ADR_CTRL, {26'h0, 1'b0, k[2], k[1], 3'h2});
      wreg(ADR_CTRL, {26'h0, 1'b0, k[2], k[1], 3'h7});
      wreg(ADR_CTRL, {26'h0, 1'b0, k[2], k[1], 3'h3});
      n0 = n_rx;
      wait_rx(n0 + 1);
      wait_high();
      chk(low_run, ex * BT, "break length");
      if (k == 0) begin
        chk(rx_data, 8'h00, "break data");
        chk(rx_fe, 1'b1, "break framing");
      end
    end
    wreg(ADR_BAUD, {19'h0, DIV});
    n0 = n_rx;
    // queue-break still set at the first break load, cleared before the second: two breaks
    wreg(ADR_CTRL, 32'h7);
    repeat (5 * BT) @(posedge clk_i);
    wreg(ADR_CTRL, 32'h3);
    wait_rx(n0 + 1);
    wait_high();
    chk(low_run, 20 * BT, "break requeued");
    repeat (2 * BT) @(posedge clk_i);
    wreg(ADR_CTRL, 32'h23);
    repeat (4) @(posedge clk_i);
    chk(txd_o, 1'b0, "inverted idle");
    end_sim();
  end
endmodule
